// *** adc_spi_pkg.sv ***
package adc_spi_pkg;

  // ****************************************************************
  // register map of the converter front end
  // ****************************************************************
  localparam int          REG_COUNT          = 27;
  localparam logic [4:0]  REG_CH0_LO         = 5'h02;
  localparam logic [4:0]  REG_CH1_LO         = 5'h05;
  localparam logic [4:0]  REG_FIRST_WRITABLE = 5'h06;
  localparam logic [4:0]  REG_STATUS         = 5'h0A;
  localparam logic [4:0]  REG_LAST           = 5'h1A;
  localparam logic [4:0]  MAP_FIRST          = 5'h00;

  // register groups, first and last address of each
  localparam logic [4:0]  GRP_FIRST [0:6] = '{5'h00, 5'h03, 5'h06, 5'h0A, 5'h0E, 5'h14, 5'h1A};
  localparam logic [4:0]  GRP_LAST  [0:6] = '{5'h02, 5'h05, 5'h09, 5'h0D, 5'h13, 5'h19, 5'h1A};

  // register types: channel data, then configuration
  localparam logic [4:0]  TYPE_DATA_LAST     = 5'h05;

  // ****************************************************************
  // comm_status_config byte fields and reset value
  // ****************************************************************
  localparam int          LOOP_MSB           = 7;
  localparam int          LOOP_LSB           = 6;
  localparam int          WINC_BIT           = 5;
  localparam int          WIDTH_MSB          = 4;
  localparam int          WIDTH_LSB          = 3;
  localparam logic [7:0]  STATUS_RESET       = 8'hA0;

  localparam logic [1:0]  LOOP_HOLD          = 2'h0;
  localparam logic [1:0]  LOOP_GROUP         = 2'h1;
  localparam logic [1:0]  LOOP_TYPE          = 2'h2;
  localparam logic [1:0]  LOOP_MAP           = 2'h3;
  localparam logic [1:0]  WIDTH_ALL16        = 2'h0;
  localparam logic [1:0]  WIDTH_ALL24        = 2'h3;

  // ****************************************************************
  // control byte layout
  // ****************************************************************
  localparam int          CTRL_DEV_MSB       = 7;
  localparam int          CTRL_DEV_LSB       = 6;
  localparam int          CTRL_REG_MSB       = 5;
  localparam int          CTRL_REG_LSB       = 1;
  localparam int          CTRL_RW_BIT        = 0;
  localparam logic [1:0]  DEV_ADDR_DEFAULT   = 2'h0;
  localparam logic [2:0]  SYNC_RESET         = 3'h4;

  // ****************************************************************
  // host controller registers and timing
  // ****************************************************************
  localparam logic [3:0]  HOST_REG_CTRL      = 4'h0;
  localparam logic [3:0]  HOST_REG_LEN       = 4'h1;
  localparam logic [3:0]  HOST_REG_TX        = 4'h2;
  localparam logic [3:0]  HOST_REG_RX        = 4'h3;
  localparam logic [3:0]  HOST_REG_STAT      = 4'h4;
  localparam logic [3:0]  HOST_REG_MODE      = 4'h5;
  localparam logic [3:0]  SCK_HALF_LAST      = 4'h7;

  // ****************************************************************
  // state encodings
  // ****************************************************************
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_CTRL  = 5'h02,
    ST_READ  = 5'h04,
    ST_WRITE = 5'h08,
    ST_SKIP  = 5'h10
  } dev_state_t;

  typedef enum logic [5:0] {
    H_IDLE = 6'h01,
    H_LEAD = 6'h02,
    H_LOW  = 6'h04,
    H_HIGH = 6'h08,
    H_WAIT = 6'h10,
    H_TAIL = 6'h20
  } host_state_t;

endpackage

// *** spi_link_if.sv ***
`timescale 1ns/10ps
interface spi_link_if;
  logic cs_n;
  logic sck;
  logic sdi;
  logic sdo_o;
  logic sdo_oe;
  logic sdo;

  // released line reads high, as with a pull-up
  assign sdo = sdo_oe ? sdo_o : 1'h1;

  modport device (input cs_n, input sck, input sdi, output sdo_o, output sdo_oe);
  modport host   (output cs_n, output sck, output sdi, input sdo);
endinterface

// *** adc_spi_device.sv ***
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
// What this block does
// - modes 0,0 and 1,1: shift fall, sample rise
// - chip select frames each independent transaction
// - select high: output released, inputs ignored
// - host sends control byte first, then bytes
// - control byte: device, register, direction fields
// - act only when device address matches
// - undefined address reads return zero bytes
// - undefined address writes change nothing
// - read starts at given address, then loops
// - write increment wraps to first writable
// - increment off: all bytes one address
// - non-writable register writes change nothing
// - output released during whole write
// - host changes clock polarity only deselected
// - channel results read as consecutive bytes
// - pulse ready output low on new data
// - hard reset restores all default values
// - loop codes: hold, group, type, map
// - sixteen-bit width skips unused low byte
module adc_spi_device
  import adc_spi_pkg::*;
#(
  parameter logic [1:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
  input  wire logic        clock,
  input  wire logic        reset_n,
  spi_link_if.device       link,
  input  wire logic        sample_valid,
  input  wire logic [23:0] ch0_sample,
  input  wire logic [23:0] ch1_sample,
  output logic             conv_ready_pulse_n,
  output logic [7:0]       comm_status_config
);

  // ****************************************************************
  // address sequencing
  // ****************************************************************

  // next read address, taken as a byte is loaded to go out
  function automatic logic [4:0] next_read(
    input logic [4:0] a,
    input logic [1:0] loop,
    input logic [1:0] width
  );
    logic [4:0] lo;
    logic [4:0] hi;
    logic [4:0] n;
    lo = MAP_FIRST;
    hi = REG_LAST;
    n  = a;
    // bounds of the set the counter loops in
    if (loop == LOOP_GROUP) begin
      for (int i = 6; i >= 0; i--) begin
        if (a <= GRP_LAST[i]) begin
          lo = GRP_FIRST[i];
          hi = GRP_LAST[i];
        end
      end
    end else if (loop == LOOP_TYPE) begin
      lo = (a <= TYPE_DATA_LAST) ? MAP_FIRST : REG_FIRST_WRITABLE;
      hi = (a <= TYPE_DATA_LAST) ? TYPE_DATA_LAST : REG_LAST;
    end
    n = a + 5'h01;
    // short channels have no low byte to fetch
    if (n == REG_CH0_LO && width == WIDTH_ALL16) begin
      n = n + 5'h01;
    end
    if (n == REG_CH1_LO && width != WIDTH_ALL24) begin
      n = n + 5'h01;
    end
    if (n > hi) begin
      n = lo;
    end
    // hold code, and undefined addresses, stay put
    if (loop == LOOP_HOLD || a > REG_LAST) begin
      n = a;
    end
    return n;
  endfunction

  // ****************************************************************
  // pin synchronisers and edge detection
  // ****************************************************************
  logic [2:0]  sync1_r;
  logic [2:0]  sync2_r;
  logic        sck_prev_r;
  wire  logic  cs_n_s;
  wire  logic  sck_s;
  wire  logic  sdi_s;
  wire  logic  sck_rise;
  wire  logic  sck_fall;

  // two flops on select, clock and data in
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sync1_r    <= SYNC_RESET;
      sync2_r    <= SYNC_RESET;
      sck_prev_r <= 1'h0;
    end else begin
      sync1_r    <= {link.cs_n, link.sck, link.sdi};
      sync2_r    <= sync1_r;
      sck_prev_r <= sync2_r[1];
    end
  end

  assign cs_n_s   = sync2_r[2];
  assign sck_s    = sync2_r[1];
  assign sdi_s    = sync2_r[0];
  // edges only count while selected
  assign sck_rise = !cs_n_s && sck_s && !sck_prev_r;
  assign sck_fall = !cs_n_s && !sck_s && sck_prev_r;

  // ****************************************************************
  // transaction state
  // ****************************************************************
  dev_state_t  state_r;
  dev_state_t  state_nxt;
  logic [2:0]  bit_cnt_r;
  logic [7:0]  in_sh_r;
  logic [7:0]  out_sh_r;
  logic [4:0]  addr_r;
  logic        driving_r;
  logic [7:0]  regs_r [REG_COUNT];

  wire  logic [7:0] in_byte;
  wire  logic       byte_done;
  wire  logic       dev_hit;
  wire  logic       is_read;
  wire  logic [4:0] ctrl_addr;
  wire  logic       writable;
  wire  logic [7:0] read_byte;
  wire  logic [1:0] loop_sel;
  wire  logic [1:0] width_sel;
  wire  logic       write_inc;
  wire  logic [4:0] rd_next;
  wire  logic [4:0] wr_next;
  wire  logic       load_out;
  wire  logic       write_now;

  // decode of the byte being shifted in
  assign in_byte   = {in_sh_r[6:0], sdi_s};
  assign byte_done = sck_rise && (bit_cnt_r == 3'h7);
  assign dev_hit   = in_byte[CTRL_DEV_MSB:CTRL_DEV_LSB] == DEV_ADDR;
  assign is_read   = in_byte[CTRL_RW_BIT];
  assign ctrl_addr = in_byte[CTRL_REG_MSB:CTRL_REG_LSB];

  // map properties of the current address
  assign writable  = (addr_r >= REG_FIRST_WRITABLE) && (addr_r <= REG_LAST);
  assign read_byte = (addr_r <= REG_LAST) ? regs_r[addr_r] : 8'h00;

  // looping settings live in the status byte
  assign loop_sel  = regs_r[REG_STATUS][LOOP_MSB:LOOP_LSB];
  assign width_sel = regs_r[REG_STATUS][WIDTH_MSB:WIDTH_LSB];
  assign write_inc = regs_r[REG_STATUS][WINC_BIT];
  assign rd_next   = next_read(addr_r, loop_sel, width_sel);
  assign wr_next   = !write_inc ? addr_r :
                     (addr_r == REG_LAST) ? REG_FIRST_WRITABLE :
                     addr_r + 5'h01;

  // a read byte is loaded at a falling edge on a byte boundary
  assign load_out  = sck_fall && (state_r == ST_READ) && (bit_cnt_r == 3'h0);
  assign write_now = byte_done && (state_r == ST_WRITE) && writable;

  // next transaction state
  always_comb begin
    state_nxt = state_r;
    if (cs_n_s) begin
      state_nxt = ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          state_nxt = ST_CTRL;
        end
        ST_CTRL: begin
          if (byte_done) begin
            state_nxt = !dev_hit ? ST_SKIP : (is_read ? ST_READ : ST_WRITE);
          end
        end
        ST_READ, ST_WRITE, ST_SKIP: begin
          state_nxt = state_r;
        end
      endcase
    end
  end

  // state, bit count and input shifter
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r   <= ST_IDLE;
      bit_cnt_r <= 3'h0;
      in_sh_r   <= 8'h00;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_IDLE) begin
        bit_cnt_r <= 3'h0;
      end else if (sck_rise) begin
        bit_cnt_r <= bit_cnt_r + 3'h1;
      end
      if (sck_rise) begin
        in_sh_r <= in_byte;
      end
    end
  end

  // internal address counter
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      addr_r <= 5'h00;
    end else if (state_r == ST_CTRL && byte_done) begin
      addr_r <= ctrl_addr;
    end else if (load_out) begin
      addr_r <= rd_next;
    end else if (write_now) begin
      addr_r <= wr_next;
    end
  end

  // ****************************************************************
  // serial output
  // ****************************************************************

  // load a new byte or shift, msb first
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      out_sh_r  <= 8'h00;
      driving_r <= 1'h0;
    end else begin
      if (load_out) begin
        out_sh_r <= read_byte;
      end else if (sck_fall && state_r == ST_READ) begin
        out_sh_r <= {out_sh_r[6:0], 1'h0};
      end
      if (state_r != ST_READ) begin
        driving_r <= 1'h0;
      end else if (load_out) begin
        driving_r <= 1'h1;
      end
    end
  end

  assign link.sdo_o  = out_sh_r[7];
  // drive only during a selected read
  assign link.sdo_oe = driving_r && (state_r == ST_READ) && !cs_n_s;

  // ****************************************************************
  // register storage and conversion ready
  // ****************************************************************

  // channel data from the converter, settings from the link
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_r[i] <= 8'h00;
      end
      regs_r[REG_STATUS] <= STATUS_RESET;
    end else begin
      if (sample_valid) begin
        regs_r[0] <= ch0_sample[23:16];
        regs_r[1] <= ch0_sample[15:8];
        regs_r[2] <= ch0_sample[7:0];
        regs_r[3] <= ch1_sample[23:16];
        regs_r[4] <= ch1_sample[15:8];
        regs_r[5] <= ch1_sample[7:0];
      end
      if (write_now) begin
        regs_r[addr_r] <= in_byte;
      end
    end
  end

  // one-cycle low pulse per new sample
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      conv_ready_pulse_n <= 1'h1;
    end else begin
      conv_ready_pulse_n <= !sample_valid;
    end
  end

  assign comm_status_config = regs_r[REG_STATUS];

endmodule

// *** adc_spi_host.sv ***
`timescale 1ns/10ps
module adc_spi_host
  import adc_spi_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reset_n,
  spi_link_if.host        link,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata
);

  // ****************************************************************
  // declarations and decode
  // ****************************************************************
  host_state_t st_r;
  host_state_t st_nxt;
  logic [3:0]  tmr_r;
  logic [2:0]  bit_r;
  logic [7:0]  tx_sh_r;
  logic [7:0]  rx_sh_r;
  logic [7:0]  rx_r;
  logic [7:0]  len_r;
  logic [7:0]  left_r;
  logic        ctrl_byte_r;
  logic        rx_full_r;
  logic        cpol_r;
  logic        sck_r;
  logic        sdi_r;
  logic        cs_n_r;
  logic [1:0]  sdo_sync_r;

  wire logic       sdo_s;
  wire logic       tmr_end;
  wire logic       bit_end;
  wire logic       byte_end;
  wire logic       wr_ctrl;
  wire logic       wr_tx;
  wire logic       wr_mode;
  wire logic       rd_rx;
  wire logic [7:0] rx_byte;
  wire logic [7:0] rd_mux;

  assign sdo_s    = sdo_sync_r[1];
  assign tmr_end  = tmr_r == SCK_HALF_LAST;
  assign bit_end  = (st_r == H_HIGH) && tmr_end;
  assign byte_end = bit_end && (bit_r == 3'h7);
  // control byte starts a frame; select low until the count is done
  assign wr_ctrl  = reg_wr && reg_addr == HOST_REG_CTRL && st_r == H_IDLE;
  assign wr_tx    = reg_wr && reg_addr == HOST_REG_TX && st_r == H_WAIT;
  assign wr_mode  = reg_wr && reg_addr == HOST_REG_MODE && st_r == H_IDLE;
  assign rd_rx    = reg_rd && reg_addr == HOST_REG_RX;
  assign rx_byte  = {rx_sh_r[6:0], sdo_s};

  // register read selection
  assign rd_mux = (reg_addr == HOST_REG_LEN)  ? len_r :
                  (reg_addr == HOST_REG_RX)   ? rx_r :
                  (reg_addr == HOST_REG_STAT) ? {5'h00, rx_full_r, st_r == H_WAIT,
                                                 st_r != H_IDLE} :
                  (reg_addr == HOST_REG_MODE) ? {7'h00, cpol_r} : 8'h00;

  // ****************************************************************
  // frame sequencer
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      H_IDLE: if (wr_ctrl) st_nxt = H_LEAD;
      H_LEAD: if (tmr_end) st_nxt = H_LOW;
      H_LOW:  if (tmr_end) st_nxt = H_HIGH;
      H_HIGH: begin
        if (tmr_end) begin
          if (bit_r != 3'h7) st_nxt = H_LOW;
          else if (left_r == 8'h00) st_nxt = H_TAIL;
          else st_nxt = H_WAIT;
        end
      end
      H_WAIT: if (wr_tx) st_nxt = H_LOW;
      H_TAIL: if (tmr_end) st_nxt = H_IDLE;
    endcase
  end

  // state, timing and shifters
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_r    <= H_IDLE;
      tmr_r   <= 4'h0;
      bit_r   <= 3'h0;
      tx_sh_r <= 8'h00;
      rx_sh_r <= 8'h00;
      left_r  <= 8'h00;
    end else begin
      st_r  <= st_nxt;
      tmr_r <= (st_nxt != st_r) ? 4'h0 : tmr_r + 4'h1;
      if (bit_end) begin
        bit_r   <= bit_r + 3'h1;
        tx_sh_r <= {tx_sh_r[6:0], 1'h0};
        rx_sh_r <= rx_byte;
      end else if (wr_ctrl || wr_tx) begin
        tx_sh_r <= reg_wdata;
      end
      if (wr_ctrl) begin
        left_r <= len_r;
      end else if (wr_tx) begin
        left_r <= left_r - 8'h01;
      end
    end
  end

  // software visible registers; a new byte beats a clearing read
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      len_r       <= 8'h00;
      rx_r        <= 8'h00;
      rx_full_r   <= 1'h0;
      ctrl_byte_r <= 1'h0;
      cpol_r      <= 1'h0;
      reg_rdata   <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == HOST_REG_LEN) len_r <= reg_wdata;
      if (wr_mode) cpol_r <= reg_wdata[0];
      if (wr_ctrl) ctrl_byte_r <= 1'h1;
      else if (byte_end) ctrl_byte_r <= 1'h0;
      if (byte_end && !ctrl_byte_r) begin
        rx_r      <= rx_byte;
        rx_full_r <= 1'h1;
      end else if (rd_rx) begin
        rx_full_r <= 1'h0;
      end
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // ****************************************************************
  // link pins
  // ****************************************************************

  // clock rests at polarity, data changes in the low half
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sck_r      <= 1'h0;
      sdi_r      <= 1'h0;
      cs_n_r     <= 1'h1;
      sdo_sync_r <= 2'h0;
    end else begin
      sck_r      <= (st_nxt == H_HIGH) || (cpol_r && st_nxt != H_LOW);
      sdi_r      <= tx_sh_r[7];
      cs_n_r     <= st_nxt == H_IDLE;
      sdo_sync_r <= {sdo_sync_r[0], link.sdo};
    end
  end

  assign link.cs_n = cs_n_r;
  assign link.sck  = sck_r;
  assign link.sdi  = sdi_r;

endmodule

// *** adc_frontend_spi_checker.sv ***
`timescale 1ns/10ps
module adc_frontend_spi_checker
  import adc_spi_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdi,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  input wire logic sdo
);
  // ********
  // frame decoder
  // ********
  logic       sck_q_r;
  logic [3:0] cnt_r;
  logic [7:0] ctrl_r;
  wire        rise    = sck & ~sck_q_r;
  wire        seen    = (cnt_r >= 4'h8) && !cs_n;
  wire        rd_ok   = (cnt_r == 4'h8) && !cs_n && ctrl_r[0] && (ctrl_r[7:6] == DEV_ADDR_DEFAULT);

  // count rising sck edges in a frame and collect the control byte
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sck_q_r <= 1'h0;
      cnt_r <= 4'h0;
      ctrl_r <= 8'h00;
    end else begin
      sck_q_r <= sck;
      if (cs_n) cnt_r <= 4'h0;
      else if (rise && cnt_r != 4'hF) cnt_r <= cnt_r + 4'h1;
      if (rise && cnt_r < 4'h8) ctrl_r <= {ctrl_r[6:0], sdi}; // msb first
    end
  end

  // ********
  // link checks
  // ********
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence lead_s;
    (!cs_n && $stable(sck)) [*8];
  endsequence

  idle_release_a: assert property (cs_n [*5] |-> !sdo_oe && sdo)
    else $error("output driven while deselected");
  frame_lead_a: assert property ($fell(cs_n) |-> lead_s)
    else $error("frame start too short");
  sck_high_a: assert property ($rose(sck) |-> sck [*8])
    else $error("sck high half wrong");
  sck_low_a: assert property ($fell(sck) |-> !sck [*8])
    else $error("sck low half wrong");
  sdi_hold_a: assert property ($rose(sck) && !cs_n |-> ##1 $stable(sdi) [*7])
    else $error("sdi moved while sck high");
  write_quiet_a: assert property (seen && !ctrl_r[0] |-> !sdo_oe)
    else $error("output driven in write");
  foreign_quiet_a: assert property (seen && ctrl_r[7:6] != DEV_ADDR_DEFAULT |-> !sdo_oe)
    else $error("output driven for other device");
  read_drive_a: assert property (rd_ok && $fell(sck) |-> ##6 sdo_oe)
    else $error("read data not driven");
  sdo_hold_a: assert property ($rose(sck) && sdo_oe |-> ##1 $stable(sdo_o) [*6])
    else $error("sdo moved while sck high");
  reset_idle_a: assert property ($rose(reset_n) |-> cs_n && !sdo_oe)
    else $error("link busy after reset");
endmodule

// *** tb_adc_frontend_spi_slave.sv ***
`timescale 1ns/10ps
module tb_adc_frontend_spi_slave
  import adc_spi_pkg::*;
;
  logic        clock = 1'h0;
  logic        reset_n;
  logic        reg_wr;
  logic        reg_rd;
  logic        sample_valid;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic [23:0] ch0_sample;
  logic [23:0] ch1_sample;
  logic        conv_ready_pulse_n;
  logic [7:0]  comm_status_config;
  int          mem [0:31];
  int          seed = 1;
  int          mismatches = 0;
  int          checked = 0;

  // ********
  // design, link and checker
  // ********
  spi_link_if spi_link_if_i ();
  adc_spi_device adc_spi_device_i (.clock, .reset_n, .link(spi_link_if_i), .sample_valid,
    .ch0_sample, .ch1_sample, .conv_ready_pulse_n, .comm_status_config);
  adc_spi_host adc_spi_host_i (.clock, .reset_n, .link(spi_link_if_i), .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata);
  adc_frontend_spi_checker checker_i (.clock, .reset_n, .cs_n(spi_link_if_i.cs_n),
    .sck(spi_link_if_i.sck), .sdi(spi_link_if_i.sdi), .sdo_o(spi_link_if_i.sdo_o),
    .sdo_oe(spi_link_if_i.sdo_oe), .sdo(spi_link_if_i.sdo));

  // clock generator
  always #10 clock = ~clock;

  // ********
  // tasks
  // ********
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task results();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clock);
    reg_wr <= 1'h0;
  endtask

  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clock);
    reg_rd <= 1'h0;
    @(negedge clock);
    d = reg_rdata;
  endtask

  // poll one status bit under a bounded count
  task poll(input int k, input logic v);
    logic [7:0] s;
    int t;
    t = 0;
    do begin
      rd(HOST_REG_STAT, s);
      t++;
    end while (s[k] !== v && t < 3000);
    chk({7'h0, s[k]}, {7'h0, v});
  endtask

  // reference for the read address counter
  function automatic int nxt(int p);
    int l, w, q, r;
    l = mem[10][7:6];
    w = mem[10][4:3];
    q = p;
    if (p > 26 || l == 0) return p;
    do begin
      r = q + 1;
      if (l == 3) r = (q == 26) ? 0 : q + 1;
      else if (l == 2) r = (q == 5) ? 0 : ((q == 26) ? 6 : q + 1);
      else for (int g = 0; g < 7; g++) if (q == GRP_LAST[g]) r = GRP_FIRST[g];
      q = r;
    end while ((q == 2 && w == 0) || (q == 5 && w != 3));
    return q;
  endfunction

  // one frame through the host, compared byte by byte with the model
  task xfer(input logic [1:0] d, input int a, input logic w, input int n, input int v);
    int p;
    logic [7:0] b, g;
    p = a;
    wr(HOST_REG_LEN, 8'(n));
    wr(HOST_REG_CTRL, {d, 5'(a), w});
    repeat (n) begin
      poll(1, 1'h1);
      b = (v < 0) ? 8'($random(seed)) : 8'(v);
      wr(HOST_REG_TX, b);
      poll(2, 1'h1);
      rd(HOST_REG_RX, g);
      if (d != DEV_ADDR_DEFAULT || !w) chk(g, 8'hFF);
      else begin
        chk(g, (p > 26) ? 8'h00 : 8'(mem[p]));
        p = nxt(p);
      end
      if (d == DEV_ADDR_DEFAULT && !w && p > 5 && p < 27) begin
        mem[p] = b;
        if (mem[10][5]) p = (p == 26) ? 6 : p + 1;
      end
    end
    poll(0, 1'h0);
    chk(comm_status_config, 8'(mem[10]));
  endtask

  task samp();
    logic [23:0] c0, c1;
    c0 = 24'($random(seed));
    c1 = 24'($random(seed));
    @(posedge clock);
    sample_valid <= 1'h1;
    ch0_sample <= c0;
    ch1_sample <= c1;
    @(posedge clock);
    sample_valid <= 1'h0;
    for (int i = 0; i < 3; i++) begin
      mem[i] = c0[23-8*i -: 8];
      mem[i+3] = c1[23-8*i -: 8];
    end
    @(negedge clock);
    chk({7'h0, conv_ready_pulse_n}, 8'h00);
    @(negedge clock);
    chk({7'h0, conv_ready_pulse_n}, 8'h01);
  endtask

  // ********
  // main sequence
  // ********
  initial begin
    {reset_n, reg_wr, reg_rd, sample_valid, reg_addr, reg_wdata} = '0;
    {ch0_sample, ch1_sample} = '0;
    for (int i = 0; i < 32; i++) mem[i] = 0;
    mem[10] = 8'hA0;
    repeat (12) @(posedge clock);
    reset_n <= 1'h1;
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk(comm_status_config, STATUS_RESET);
    chk({7'h0, conv_ready_pulse_n}, 8'h01);
    xfer(2'h0, 11, 1'h0, 20, -1);
    xfer(2'h0, 10, 1'h0, 1, 8'hD8);
    xfer(2'h0, 12, 1'h0, 3, -1);
    xfer(2'h0, 1, 1'h0, 1, -1);
    xfer(2'h0, 29, 1'h0, 2, -1);
    xfer(2'h1, 12, 1'h0, 1, -1);
    xfer(2'h0, 1, 1'h1, 1, -1);
    xfer(2'h0, 12, 1'h1, 1, -1);
    for (int l = 0; l < 4; l++) begin
      wr(HOST_REG_MODE, 8'(l & 1));
      samp();
      for (int k = 0; k < 3; k++) begin
        xfer(2'h0, 10, 1'h0, 1, l * 64 + 32 + ((k == 2) ? 24 : k * 8));
        xfer(2'h0, 25, 1'h1, 4, -1);
        xfer(2'h0, 1, 1'h1, 6, -1);
      end
      xfer(2'h0, 29, 1'h1, 2, -1);
      xfer(2'h2, 0, 1'h1, 1, -1);
    end
    results();
  end

  // watchdog against a hung handshake
  initial begin
    repeat (90000) @(posedge clock);
    mismatches++;
    results();
  end
endmodule
